// *** hdl/psc_pkg.sv ***
package psc_pkg;

    // ==========================================================================
    // Register map.
    localparam logic [11:0] PSC_OFF_OSC_CTRL = 12'h000;
    localparam logic [11:0] PSC_OFF_MOD_DIS7 = 12'h004;
    localparam logic [11:0] PSC_OFF_PWR_CTRL = 12'h008;
    localparam logic [11:0] PSC_OFF_STATUS   = 12'h00c;

    // ==========================================================================
    // Field positions.
    localparam int PSC_NOSC_HI    = 10;
    localparam int PSC_NOSC_LO    = 8;
    localparam int PSC_DMA_BIT    = 4;
    localparam int PSC_TRIG_BIT   = 3;
    localparam int PSC_DOZE_BIT   = 0;
    localparam int PSC_DZDIV_LO   = 1;
    localparam int PSC_DZDIV_HI   = 3;
    localparam int PSC_CLKDIV_LO  = 4;
    localparam int PSC_CLKDIV_HI  = 6;

    // ==========================================================================
    // Reset values and the module-disable write mask.
    localparam logic [2:0]  PSC_NOSC_RST   = 3'h0;
    localparam logic [15:0] PSC_MD7_RST    = 16'h0000;
    localparam logic [15:0] PSC_MD7_MASK   = 16'h0018;
    localparam logic [6:0]  PSC_PWR_RST    = 7'h00;

    // ==========================================================================
    // Power-save instruction operands and states.
    localparam logic [1:0]  PSC_OP_SLEEP   = 2'h0;
    localparam logic [1:0]  PSC_OP_IDLE    = 2'h1;

    typedef enum logic [1:0] {
        PSC_RUN   = 2'b00,
        PSC_SLEEP = 2'b01,
        PSC_IDLE  = 2'b10
    } psc_state_t;

endpackage : psc_pkg

// *** hdl/psc_clk_div.sv ***
`timescale 1ns/1ps
module psc_clk_div
    import psc_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       run,
    input  wire logic [2:0] ratioSel,
    output logic            tick
);

    logic [7:0] cnt_r;
    logic [7:0] limit;

    assign limit = 8'((9'h1 << ratioSel) - 9'h1);

    // ==========================================================================
    // Enable pulse every 2**ratioSel cycles while running.
    always_ff @(posedge ref_clk)
    begin
        if (rst || !run)
        begin
            cnt_r <= 8'h00;
            tick  <= 1'b0;
        end
        else if (cnt_r >= limit)
        begin
            cnt_r <= 8'h00;
            tick  <= 1'b1;
        end
        else
        begin
            cnt_r <= cnt_r + 8'h01;
            tick  <= 1'b0;
        end
    end

endmodule : psc_clk_div

// *** hdl/psc_apb_slave.sv ***
`timescale 1ns/1ps
module psc_apb_slave
    import psc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    output logic             pready,
    output logic             pslverr,
    output logic             wrStb,
    output logic [11:0]      accAddr,
    output logic             rdStb,
    input  wire logic        addrOk
);

    // ==========================================================================
    // Write strobe marks the access edge; read strobe marks the setup edge.
    always_comb
    begin
        wrStb   = psel && penable && pwrite;
        rdStb   = psel && !penable && !pwrite;
        accAddr = paddr;
    end

    // ==========================================================================
    // Zero wait states; the error flag is registered in the setup cycle.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pready  <= 1'b1;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= 1'b1;
            pslverr <= psel && !penable && !addrOk;
        end
    end

endmodule : psc_apb_slave

// *** hdl/psc_power_save_control.sv ***
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module psc_power_save_control
    import psc_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pwrSaveExec,
    input  wire logic [1:0]  pwrSaveOperand,
    input  wire logic        intWake,
    input  wire logic        wdtTimeout,
    input  wire logic        clkCfgLock,
    output logic             cpuClkEn,
    output logic             periphClkEn,
    output logic             cpuHalt,
    output logic [2:0]       newOscSelect,
    output logic             dmaChanDisable,
    output logic             trigGenDisable,
    output logic [1:0]       pwrState
);

    psc_state_t  state_r;
    psc_state_t  state_nxt;
    logic [15:0] osc_r;
    logic [15:0] md7_r;
    logic [6:0]  pwr_r;
    logic        wrStb;
    logic        rdStb;
    logic [11:0] accAddr;
    logic        addrOk;
    logic        sysTick;
    logic        dozeTick;
    logic        cpuTick;
    logic        wake;
    logic        selOsc;
    logic        selMd7;
    logic        selPwr;
    logic        selStat;
    logic [31:0] rdMux;

    // ==========================================================================
    // Bus slave.
    assign selOsc  = (accAddr == PSC_OFF_OSC_CTRL);
    assign selMd7  = (accAddr == PSC_OFF_MOD_DIS7);
    assign selPwr  = (accAddr == PSC_OFF_PWR_CTRL);
    assign selStat = (accAddr == PSC_OFF_STATUS);
    assign addrOk  = selOsc || selMd7 || selPwr || selStat;

    psc_apb_slave u_apb (
        .ref_clk (ref_clk),
        .rst     (rst),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pready  (pready),
        .pslverr (pslverr),
        .wrStb   (wrStb),
        .accAddr (accAddr),
        .rdStb   (rdStb),
        .addrOk  (addrOk)
    );

    // ==========================================================================
    // Oscillator control register.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            osc_r <= 16'h0000;
        end
        else if (wrStb && selOsc && !clkCfgLock)
        begin
            osc_r[PSC_NOSC_HI:PSC_NOSC_LO] <= pwdata[PSC_NOSC_HI:PSC_NOSC_LO];
        end
    end

    // ==========================================================================
    // Module-disable register seven.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            md7_r <= PSC_MD7_RST;
        end
        else if (wrStb && selMd7)
        begin
            md7_r <= pwdata[15:0] & PSC_MD7_MASK;
        end
    end

    // ==========================================================================
    // Power control: doze enable, doze ratio and clock scaling ratio.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pwr_r <= PSC_PWR_RST;
        end
        else if (wrStb && selPwr)
        begin
            pwr_r <= pwdata[6:0];
        end
    end

    // ==========================================================================
    // Clock scaling and doze dividers.
    psc_clk_div u_sysdiv (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .run      (state_r != PSC_SLEEP),
        .ratioSel (pwr_r[PSC_CLKDIV_HI:PSC_CLKDIV_LO]),
        .tick     (sysTick)
    );

    psc_clk_div u_dozediv (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .run      (sysTick || pwr_r[PSC_DOZE_BIT]),
        .ratioSel (pwr_r[PSC_DZDIV_HI:PSC_DZDIV_LO]),
        .tick     (dozeTick)
    );

    assign cpuTick = pwr_r[PSC_DOZE_BIT] ? (dozeTick && sysTick) : sysTick;

    // ==========================================================================
    // Power state machine.
    assign wake = intWake || wdtTimeout;

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            PSC_RUN:
            begin
                if (pwrSaveExec && pwrSaveOperand == PSC_OP_SLEEP)
                    state_nxt = PSC_SLEEP;
                else if (pwrSaveExec && pwrSaveOperand == PSC_OP_IDLE)
                    state_nxt = PSC_IDLE;
            end
            PSC_SLEEP, PSC_IDLE:
            begin
                if (wake)
                    state_nxt = PSC_RUN;
            end
            default:
                state_nxt = PSC_RUN;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            state_r <= PSC_RUN;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================================
    // Clock enables for the CPU and the peripherals.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            cpuClkEn <= 1'b0;
        end
        else
        begin
            cpuClkEn <= (state_nxt == PSC_RUN) && cpuTick;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            periphClkEn <= 1'b0;
        end
        else
        begin
            periphClkEn <= (state_nxt != PSC_SLEEP) && sysTick;
        end
    end

    // ==========================================================================
    // Halt flag and power state.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            cpuHalt <= 1'b0;
        end
        else
        begin
            cpuHalt <= (state_nxt != PSC_RUN);
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pwrState <= 2'h0;
        end
        else
        begin
            pwrState <= state_nxt;
        end
    end

    // ==========================================================================
    // Oscillator select and module disables.
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            newOscSelect <= PSC_NOSC_RST;
        end
        else
        begin
            newOscSelect <= osc_r[PSC_NOSC_HI:PSC_NOSC_LO];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            dmaChanDisable <= 1'b0;
        end
        else
        begin
            dmaChanDisable <= md7_r[PSC_DMA_BIT];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            trigGenDisable <= 1'b0;
        end
        else
        begin
            trigGenDisable <= md7_r[PSC_TRIG_BIT];
        end
    end

    // ==========================================================================
    // Read data.
    always_comb
    begin
        rdMux = 32'h00000000;
        if (selOsc)
        begin
            rdMux = {16'h0000, osc_r};
        end
        else if (selMd7)
        begin
            rdMux = {16'h0000, md7_r};
        end
        else if (selPwr)
        begin
            rdMux = {25'h0, pwr_r};
        end
        else if (selStat)
        begin
            rdMux = {29'h0, clkCfgLock, state_r};
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            prdata <= 32'h00000000;
        end
        else if (rdStb)
        begin
            prdata <= rdMux;
        end
    end

endmodule : psc_power_save_control

// *** test/psc_power_save_control_asserts.sv ***
`timescale 1ns/1ps
// ==========================================================================
// Port checker.
module psc_power_save_control_asserts
    import psc_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        pwrSaveExec,
    input wire logic [1:0]  pwrSaveOperand,
    input wire logic        intWake,
    input wire logic        wdtTimeout,
    input wire logic        clkCfgLock,
    input wire logic        cpuClkEn,
    input wire logic        periphClkEn,
    input wire logic        cpuHalt,
    input wire logic [2:0]  newOscSelect,
    input wire logic [1:0]  pwrState
);
    logic mapped;
    assign mapped = paddr inside {PSC_OFF_OSC_CTRL, PSC_OFF_MOD_DIS7,
                                  PSC_OFF_PWR_CTRL, PSC_OFF_STATUS};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sleep_entry_a: assert property (pwrState == 2'h0 && pwrSaveExec &&
        pwrSaveOperand == PSC_OP_SLEEP |=> pwrState == 2'h1 && cpuHalt)
        else $error("sleep not entered");
    idle_entry_a: assert property (pwrState == 2'h0 && pwrSaveExec &&
        pwrSaveOperand == PSC_OP_IDLE |=> pwrState == 2'h2 && cpuHalt)
        else $error("idle not entered");
    no_entry_a: assert property (pwrState == 2'h0 &&
        !(pwrSaveExec && pwrSaveOperand < 2'h2) |=> pwrState == 2'h0)
        else $error("low power entered without instruction");
    wake_exit_a: assert property (cpuHalt && (intWake || wdtTimeout) |=> !cpuHalt)
        else $error("no wake on event");
    halt_cpu_a: assert property (cpuHalt && $past(cpuHalt) |-> !cpuClkEn)
        else $error("cpu clocked while halted");
    sleep_periph_a: assert property (pwrState == 2'h1 && $past(pwrState) == 2'h1
        |-> !periphClkEn) else $error("peripheral clocked in sleep");
    osc_lock_a: assert property (clkCfgLock [*3] |=> $stable(newOscSelect))
        else $error("oscillator select changed while locked");
    bus_err_a: assert property (psel && penable && !mapped |-> pslverr && pready)
        else $error("no error on unmapped access");
    bus_ok_a: assert property (psel && penable && mapped |-> !pslverr && pready)
        else $error("bad answer on mapped access");
endmodule : psc_power_save_control_asserts

bind psc_power_save_control psc_power_save_control_asserts psc_asserts_inst (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .paddr(paddr),
    .pready(pready), .pslverr(pslverr), .pwrSaveExec(pwrSaveExec),
    .pwrSaveOperand(pwrSaveOperand), .intWake(intWake), .wdtTimeout(wdtTimeout),
    .clkCfgLock(clkCfgLock), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn),
    .cpuHalt(cpuHalt), .newOscSelect(newOscSelect), .pwrState(pwrState));

// *** test/test_psc_power_save_control.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, s) begin numChecks++; if ((s) !== (e)) begin failCount++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, s); end end
module test_psc_power_save_control
    import psc_pkg::*;
;
    // ======================================================================
    // Stimulus and design.
    logic        ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdq;
    logic        pready, pslverr, rderr, pwrSaveExec = 0, intWake = 0;
    logic [1:0]  pwrSaveOperand = 0, pwrState;
    logic        wdtTimeout = 0, clkCfgLock = 0, cpuClkEn, periphClkEn, cpuHalt;
    logic [2:0]  newOscSelect;
    logic        dmaChanDisable, trigGenDisable;
    int          failCount = 0, numChecks = 0, cpuN, perN;

    psc_power_save_control psc_power_save_control_inst (.ref_clk(ref_clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pwrSaveExec(pwrSaveExec),
        .pwrSaveOperand(pwrSaveOperand), .intWake(intWake), .wdtTimeout(wdtTimeout),
        .clkCfgLock(clkCfgLock), .cpuClkEn(cpuClkEn), .periphClkEn(periphClkEn),
        .cpuHalt(cpuHalt), .newOscSelect(newOscSelect), .dmaChanDisable(dmaChanDisable),
        .trigGenDisable(trigGenDisable), .pwrState(pwrState));

    initial
    begin
        forever #12.5 ref_clk = ~ref_clk;
    end

    // ======================================================================
    // Tasks.
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
        end
        while (pready !== 1'b1);
        rdq = prdata;
        rderr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask : xfer

    task automatic count16();
        cpuN = 0;
        perN = 0;
        repeat (16)
        begin
            @(negedge ref_clk);
            cpuN += int'(cpuClkEn === 1'b1);
            perN += int'(periphClkEn === 1'b1);
        end
    endtask : count16

    task automatic pwrOp(input logic [1:0] op, input logic [1:0] st, input int per);
        @(posedge ref_clk);
        pwrSaveExec <= 1'b1;
        pwrSaveOperand <= op;
        @(posedge ref_clk);
        pwrSaveExec <= 1'b0;
        repeat (2) @(posedge ref_clk);
        count16();
        `CHK("state", st, pwrState)
        `CHK("halt", st != 2'h0, cpuHalt)
        `CHK("cpu ticks", (st == 2'h0) ? 16 : 0, cpuN)
        `CHK("periph ticks", per, perN)
        xfer(1'b0, PSC_OFF_STATUS, 32'h0);
        `CHK("status state", st, rdq[1:0])
    endtask : pwrOp

    task automatic wake(input logic useInt);
        @(posedge ref_clk);
        intWake <= useInt;
        wdtTimeout <= !useInt;
        @(posedge ref_clk);
        intWake <= 1'b0;
        wdtTimeout <= 1'b0;
        @(negedge ref_clk);
        `CHK("woken", 1'b0, cpuHalt)
        `CHK("run", 2'h0, pwrState)
    endtask : wake

    task automatic md7(input logic [31:0] d);
        xfer(1'b1, PSC_OFF_MOD_DIS7, d);
        xfer(1'b0, PSC_OFF_MOD_DIS7, 32'h0);
        `CHK("md7 read", d & 32'h18, rdq)
        `CHK("dma off", d[4], dmaChanDisable)
        `CHK("trig off", d[3], trigGenDisable)
    endtask : md7

    task automatic osc(input logic lk, input logic [2:0] v, input logic [2:0] e);
        clkCfgLock <= lk;
        xfer(1'b1, PSC_OFF_OSC_CTRL, {21'h0, v, 8'h0});
        `CHK("osc select", e, newOscSelect)
    endtask : osc

    task automatic unmapped();
        xfer(1'b0, 12'h010, 32'h0);
        `CHK("unmapped err", 1'b1, rderr)
        `CHK("unmapped data", 32'h0, rdq)
        xfer(1'b0, PSC_OFF_STATUS, 32'h0);
        `CHK("mapped err", 1'b0, rderr)
    endtask : unmapped

    task automatic scale(input logic [31:0] d, input int cpu, input int per);
        xfer(1'b1, PSC_OFF_PWR_CTRL, d);
        count16();
        `CHK("scaled cpu", cpu, cpuN)
        `CHK("scaled periph", per, perN)
        xfer(1'b0, PSC_OFF_PWR_CTRL, 32'h0);
        `CHK("pwr read", d, rdq)
    endtask : scale

    task automatic resetWake();
        xfer(1'b1, PSC_OFF_MOD_DIS7, 32'h18);
        pwrOp(PSC_OP_SLEEP, 2'h1, 0);
        rst <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK("reset woken", 1'b0, cpuHalt)
        `CHK("reset run", 2'h0, pwrState)
        `CHK("osc reset", PSC_NOSC_RST, newOscSelect)
        xfer(1'b0, PSC_OFF_MOD_DIS7, 32'h0);
        `CHK("md7 after reset", 32'h0, rdq)
        `CHK("dma after reset", 1'b0, dmaChanDisable)
    endtask : resetWake

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", numChecks, failCount);
        if (failCount == 0 && numChecks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (4000) @(posedge ref_clk);
        failCount++;
        report_and_stop();
    end

    initial
    begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        xfer(1'b0, PSC_OFF_MOD_DIS7, 32'h0);
        `CHK("md7 reset", 32'h0, rdq)
        md7(32'hffffffff);
        md7(32'h00000010);
        md7(32'h00000008);
        md7(32'h0);
        osc(1'b0, 3'h7, 3'h7);
        osc(1'b1, 3'h2, 3'h7);
        osc(1'b0, 3'h3, 3'h3);
        unmapped();
        pwrOp(PSC_OP_SLEEP, 2'h1, 0);
        wake(1'b1);
        pwrOp(PSC_OP_IDLE, 2'h2, 16);
        wake(1'b0);
        pwrOp(2'h2, 2'h0, 16);
        scale(32'h3, 8, 16);
        scale(32'h10, 8, 8);
        resetWake();
        report_and_stop();
    end
endmodule : test_psc_power_save_control
